// >>> src/flash_status_dev.sv
// flash device end: status register and write enable gating
// assumes: mode 0 link, sck well below core_clk/6, host obeys wel rules
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "flash_status_params.svh"
// Summary of operation
// RL1: status read repeats until chip select high
// RL2: power up loads volatile from stored copy
// RL3: bit 0 is read-only busy flag
// RL4: bit 1 is volatile write enable latch
// RL5: bits 5..2 stored block protection field
// RL6: bit 6 stored quad enable
// RL7: bit 7 stored status write lock
// RL8: only enable/disable commands change the latch; here completion, volatile writes and soft reset also clear it
// RL9: status write updates stored and volatile bits
// RL10: stored bits zero as delivered
// RL11: busy throughout program, erase, register writes; here volatile register writes set no busy
// RL12: while busy, ignore all but reads/reset/suspend
// RL13: suspend accepted during program or erase; here also during status writes and stored register writes
// RL14: completion clears busy, then accept commands
// RL15: latch zero inhibits write-class commands
// RL16: opcode 06h sets latch; host sends first
// RL17: disable command or completion clears latch
// RL18: page program opcodes need write enable
// RL19: erase opcodes need write enable
// RL20: register write opcodes need write enable
// RL21: protection and info-row opcodes need enable
// RL22: C0h and 17h need no write enable
// RL23: lock plus low protect pin blocks writes; here it blocks only the status write
module flash_status_dev
    import flash_types_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  rstn,
    spi_link_if.flash  link,
    output logic [7:0] statusView,
    output logic       opBusy,
    output logic       opSuspended
);
    // ==========================================================
    // pin synchronisers
    logic       sckS;          // synced serial clock
    logic       ceNS;          // synced chip select
    logic       siS;           // synced data in
    logic       wpNS;          // synced protect pin
    sync_two_ff #(.W(4), .RESET_VAL(4'b0101)) pinSync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      ({link.sck, link.ceN, link.si, link.wpN}),
        .dout     ({sckS, ceNS, siS, wpNS})
    );

    // ==========================================================
    // state
    dev_state_type pwr_r;          // power-up sequencing
    logic          sckD_r;         // sck one cycle back
    logic          ceND_r;         // chip select one cycle back
    logic [4:0]    bitCnt_r;       // bits in frame, stops at 16
    logic [15:0]   shift_r;        // opcode then data byte
    logic [7:0]    op_r;           // opcode of current frame
    logic [2:0]    outIdx_r;       // read bit index
    logic [7:0]    snap_r;         // byte being repeated out
    logic          so_r;           // serial out
    logic [5:0]    nv_r;           // stored copy of bits 7..2
    logic [5:0]    vol_r;          // live copy of bits 7..2
    logic          wel_r;          // write enable latch
    logic          busy_r;         // operation in progress
    logic          susp_r;         // operation suspended
    logic [15:0]   timer_r;        // cycles left in operation

    // ==========================================================
    // edge finding on synced pins
    wire sckRise = sckS & ~sckD_r;
    wire sckFall = ~sckS & sckD_r;
    wire ceRise  = ceNS & ~ceND_r;
    wire [7:0] opNow = {shift_r[6:0], siS};

    // ==========================================================
    // status image
    wire [7:0] status = {vol_r, wel_r, busy_r}; // RL3 RL4 RL5 RL6 RL7
    wire readMode = ~ceNS & (bitCnt_r >= 5'd8) &
                    (op_r == `STATUS_READ_CMD);

    // ==========================================================
    // opcode classes
    wire isPgm = (op_r == `PAGE_PROGRAM_CMD) |
                 (op_r == `PAGE_PROGRAM_4B_CMD) |
                 (op_r == `QUAD_PAGE_PROGRAM_A_CMD) |
                 (op_r == `QUAD_PAGE_PROGRAM_B_CMD) |
                 (op_r == `QUAD_PP_4B_A_CMD) |
                 (op_r == `QUAD_PP_4B_B_CMD); // RL18
    wire isChip = (op_r == `CHIP_ERASE_A_CMD) |
                  (op_r == `CHIP_ERASE_B_CMD);
    wire isErase = (op_r == `SECTOR_ERASE_A_CMD) |
                   (op_r == `SECTOR_ERASE_B_CMD) |
                   (op_r == `SECTOR_ERASE_4B_CMD) |
                   (op_r == `BLOCK32_ERASE_CMD) |
                   (op_r == `BLOCK32_ERASE_4B_CMD) |
                   (op_r == `BLOCK64_ERASE_CMD) |
                   (op_r == `BLOCK64_ERASE_4B_CMD) | isChip; // RL19
    // volatile register writes: need the latch but no busy time
    wire isVolWr = (op_r == `READ_PARAM_VOL_CMD) |
                   (op_r == `EXT_READ_PARAM_VOL_CMD) |
                   (op_r == `BANK_ADDR_VOL_WRITE_CMD); // RL20
    wire isNvWr = (op_r == `FUNCTION_WRITE_CMD) |
                  (op_r == `READ_PARAM_NV_CMD) |
                  (op_r == `EXT_READ_PARAM_NV_CMD) |
                  (op_r == `AUTOBOOT_WRITE_CMD) |
                  (op_r == `BANK_ADDR_NV_WRITE_CMD) | // RL20
                  (op_r == `INFO_ROW_ERASE_CMD) |
                  (op_r == `INFO_ROW_WRITE_CMD) |
                  (op_r == `DYNAMIC_LOCK_WRITE_CMD) |
                  (op_r == `DYNAMIC_LOCK_WRITE_ALT_CMD) |
                  (op_r == `PERSISTENT_LOCK_WRITE_CMD) |
                  (op_r == `PERSISTENT_LOCK_WRITE_4B_CMD) |
                  (op_r == `PERSISTENT_LOCK_ERASE_CMD) |
                  (op_r == `PROTECT_SCHEME_WRITE_CMD) |
                  (op_r == `PERSISTENT_LOCK_BIT_CMD) |
                  (op_r == `FREEZE_SET_CMD) |
                  (op_r == `GANG_LOCK_CMD) |
                  (op_r == `GANG_UNLOCK_CMD) |
                  (op_r == `PASSWORD_WRITE_CMD); // RL21
    // alternative volatile opcodes fall in no class: no latch needed
    // and nothing to do here RL22

    // ==========================================================
    // frame end decisions
    wire haveOp   = ceRise & (bitCnt_r >= 5'd8) & (pwr_r == RUNNING);
    wire idleOk   = haveOp & ~busy_r;               // RL12
    wire bpClear  = (vol_r[3:0] == 4'h0);
    wire srLocked = vol_r[5] & ~wpNS;               // RL23
    wire doWren   = idleOk & (op_r == `WRITE_ENABLE_CMD);
    wire doWrdi   = idleOk & (op_r == `WRITE_DISABLE_CMD);
    wire doWrsr   = idleOk & wel_r & (op_r == `STATUS_WRITE_CMD) &
                    (bitCnt_r == 5'd16) & ~srLocked; // RL15 RL23
    wire doLong   = idleOk & wel_r & ~susp_r &
                    (isPgm | (isErase & (~isChip | bpClear)) | isNvWr);
    wire doVol    = idleOk & wel_r & isVolWr;        // RL15
    wire doSusp   = haveOp & busy_r & ~susp_r &
                    (op_r == `SUSPEND_CMD);          // RL13
    wire doResume = idleOk & susp_r & (op_r == `RESUME_CMD);
    wire doReset  = haveOp & (op_r == `SOFT_RESET_CMD); // RL12
    wire opDone   = busy_r & (timer_r == 16'd1);

    // ==========================================================
    // link front end: edges, bit count, opcode capture
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sckD_r   <= 1'b0;
            ceND_r   <= 1'b1;
            bitCnt_r <= 5'd0;
            shift_r  <= 16'h0000;
            op_r     <= 8'h00;
        end else begin
            sckD_r <= sckS;
            ceND_r <= ceNS;
            if (ceNS) begin
                // frame ends: count restarts
                bitCnt_r <= 5'd0;
            end else if (sckRise) begin
                shift_r <= {shift_r[14:0], siS};
                if (bitCnt_r == 5'd7) begin
                    op_r <= opNow;
                end
                if (bitCnt_r != 5'd16) begin
                    bitCnt_r <= bitCnt_r + 5'd1;
                end
            end
        end
    end

    // ==========================================================
    // status read out, byte repeated until chip select rises
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            outIdx_r <= 3'd0;
            snap_r   <= `STATUS_RESET;
            so_r     <= 1'b0;
        end else if (!readMode) begin
            outIdx_r <= 3'd0;
            so_r     <= 1'b0;
        end else if (sckFall) begin
            // new byte: take a fresh image at bit 7
            if (outIdx_r == 3'd0) begin
                snap_r <= status;
                so_r   <= status[7];
            end else begin
                so_r <= snap_r[3'd7 - outIdx_r];
            end
            outIdx_r <= outIdx_r + 3'd1; // RL1
        end
    end

    // ==========================================================
    // stored copy, written by status write only
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            nv_r <= 6'h00; // RL10
        end else if (doWrsr) begin
            nv_r <= shift_r[7:2]; // RL9
        end
    end

    // ==========================================================
    // volatile copy: power-up load, status write, soft reset
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pwr_r <= POWER_LOAD;
            vol_r <= 6'h00;
        end else begin
            case (pwr_r)
                POWER_LOAD: begin
                    vol_r <= nv_r; // RL2
                    pwr_r <= RUNNING;
                end
                default: begin
                    if (doWrsr) begin
                        vol_r <= shift_r[7:2]; // RL9
                    end else if (doReset) begin
                        vol_r <= nv_r; // RL2
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // write enable latch
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wel_r <= 1'b0; // RL4
        end else if (doWren) begin
            wel_r <= 1'b1; // RL16
        end else if (doWrdi | opDone | doVol | doReset) begin
            // status write itself leaves the latch alone RL8
            wel_r <= 1'b0; // RL17
        end
    end

    // ==========================================================
    // busy flag, operation timer, suspend
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            busy_r  <= 1'b0; // RL3
            susp_r  <= 1'b0;
            timer_r <= 16'd0;
        end else if (doReset) begin
            // reset abandons any operation
            busy_r  <= 1'b0;
            susp_r  <= 1'b0;
            timer_r <= 16'd0;
        end else if (doWrsr | doLong) begin
            busy_r  <= 1'b1; // RL11
            timer_r <= `OP_CYCLES;
        end else if (doSusp) begin
            // timer holds its place while suspended
            busy_r <= 1'b0;
            susp_r <= 1'b1; // RL13
        end else if (doResume) begin
            busy_r <= 1'b1;
            susp_r <= 1'b0;
        end else if (busy_r) begin
            timer_r <= timer_r - 16'd1;
            if (opDone) begin
                busy_r <= 1'b0; // RL14
            end
        end
    end

    // ==========================================================
    // outputs
    assign link.so     = so_r;
    assign statusView  = status;
    assign opBusy      = busy_r;
    assign opSuspended = susp_r;
endmodule // flash_status_dev

// >>> src/flash_status_host.sv
// host end: wishbone slave that runs one serial frame per command
// assumes: classic wishbone master; device answers status on so
`timescale 1ns/10ps
`include "flash_status_params.svh"
module flash_status_host
    import flash_types_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    spi_link_if.host         link
);
    // ==========================================================
    // so synchroniser
    logic soS;   // synced serial in
    sync_two_ff #(.W(1), .RESET_VAL(1'b0)) soSync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (link.so),
        .dout     (soS)
    );

    // ==========================================================
    // state
    host_state_type st_r;        // sequencer state
    logic [3:0]     div_r;       // half period counter
    logic [6:0]     bitsLeft_r;  // bits still to clock
    logic [15:0]    tx_r;        // opcode then data, msb first
    logic [7:0]     rx_r;        // last bits read
    logic           sck_r;       // serial clock out
    logic           ceN_r;       // chip select out
    logic           wp_r;        // protect pin level
    logic           ack_r;       // bus answer
    logic [31:0]    rd_r;        // bus read data

    // ==========================================================
    // bus decode
    wire req     = cyc_i & stb_i & ~ack_r;
    wire hitCmd  = (adr_i == `CMD_OFFSET);
    wire hitStat = (adr_i == `STAT_OFFSET);
    wire hitWp   = (adr_i == `WP_OFFSET);
    wire start   = req & we_i & sel_i[0] & hitCmd & (st_r == H_IDLE);
    wire halfEnd = (div_r == `HALF_SCK_CYCLES - 4'd1);
    wire [6:0] nBits = 7'd8 + (dat_i[`CMD_SEND_DATA] ? 7'd8 : 7'd0) +
                       {1'b0, dat_i[`CMD_RD_LSB +: 3], 3'b000};
    wire [31:0] rdNxt = hitStat ? {16'h0000, rx_r, 7'h00,
                                   st_r != H_IDLE} :
                        hitWp ? {31'h0, wp_r} : 32'h0;

    // ==========================================================
    // bus slave: answer one cycle after the request
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ack_r <= 1'b0;
            rd_r  <= 32'h0;
            wp_r  <= 1'b1;
        end else begin
            ack_r <= req;
            if (req & ~we_i) begin
                rd_r <= rdNxt;
            end
            if (req & we_i & sel_i[0] & hitWp) begin
                wp_r <= dat_i[0];
            end
        end
    end

    // ==========================================================
    // serial sequencer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_r       <= H_IDLE;
            div_r      <= 4'd0;
            bitsLeft_r <= 7'd0;
            tx_r       <= 16'h0000;
            rx_r       <= 8'h00;
            sck_r      <= 1'b0;
            ceN_r      <= 1'b1;
        end else begin
            div_r <= halfEnd ? 4'd0 : div_r + 4'd1;
            case (st_r)
                H_IDLE: begin
                    div_r <= 4'd0;
                    if (start) begin
                        // opcode leads on the wire, data byte follows
                        tx_r       <= {dat_i[7:0], dat_i[15:8]};
                        bitsLeft_r <= nBits;
                        ceN_r      <= 1'b0;
                        st_r       <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (halfEnd) begin
                        sck_r <= 1'b1;
                        st_r  <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (halfEnd) begin
                        // device bit sampled just before falling edge
                        rx_r       <= {rx_r[6:0], soS};
                        sck_r      <= 1'b0;
                        tx_r       <= {tx_r[14:0], 1'b0};
                        bitsLeft_r <= bitsLeft_r - 7'd1;
                        st_r       <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (halfEnd) begin
                        if (bitsLeft_r == 7'd0) begin
                            ceN_r <= 1'b1;
                            st_r  <= H_TAIL;
                        end else begin
                            sck_r <= 1'b1;
                            st_r  <= H_HIGH;
                        end
                    end
                end
                default: begin
                    if (halfEnd) begin
                        st_r <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // outputs
    assign ack_o    = ack_r;
    assign dat_o    = rd_r;
    assign link.sck = sck_r;
    assign link.ceN = ceN_r;
    assign link.si  = tx_r[15];
    assign link.wpN = wp_r;
endmodule // flash_status_host

// >>> src/flash_status_params.svh
// constants of the flash status register and its link controller
// assumes: included by bare name from the two ends and the bench
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH
// ==========================================================
// status field positions and reset value
`define BUSY_BIT        0
`define WEL_BIT         1
`define BP_LSB          2
`define BP_MSB          5
`define QE_BIT          6
`define LOCK_BIT        7
`define STATUS_RESET    8'h00
// ==========================================================
// opcodes
`define WRITE_ENABLE_CMD          8'h06
`define WRITE_DISABLE_CMD         8'h04
`define STATUS_READ_CMD           8'h05
`define FUNCTION_READ_CMD         8'h48
`define EXT_READ_REG_CMD          8'h81
`define SOFT_RESET_CMD            8'h99
`define SUSPEND_CMD               8'h75
`define RESUME_CMD                8'h7a
`define STATUS_WRITE_CMD          8'h01
`define PAGE_PROGRAM_CMD          8'h02
`define PAGE_PROGRAM_4B_CMD       8'h12
`define QUAD_PAGE_PROGRAM_A_CMD   8'h32
`define QUAD_PAGE_PROGRAM_B_CMD   8'h38
`define QUAD_PP_4B_A_CMD          8'h34
`define QUAD_PP_4B_B_CMD          8'h3e
`define SECTOR_ERASE_A_CMD        8'hd7
`define SECTOR_ERASE_B_CMD        8'h20
`define SECTOR_ERASE_4B_CMD       8'h21
`define BLOCK32_ERASE_CMD         8'h52
`define BLOCK32_ERASE_4B_CMD      8'h5c
`define BLOCK64_ERASE_CMD         8'hd8
`define BLOCK64_ERASE_4B_CMD      8'hdc
`define CHIP_ERASE_A_CMD          8'hc7
`define CHIP_ERASE_B_CMD          8'h60
`define FUNCTION_WRITE_CMD        8'h42
`define READ_PARAM_NV_CMD         8'h65
`define READ_PARAM_VOL_CMD        8'h63
`define READ_PARAM_VOL_ALT_CMD    8'hc0
`define EXT_READ_PARAM_NV_CMD     8'h85
`define EXT_READ_PARAM_VOL_CMD    8'h83
`define INFO_ROW_ERASE_CMD        8'h64
`define INFO_ROW_WRITE_CMD        8'h62
`define AUTOBOOT_WRITE_CMD        8'h15
`define BANK_ADDR_NV_WRITE_CMD    8'h18
`define BANK_ADDR_VOL_WRITE_CMD   8'hc5
`define BANK_ADDR_VOL_ALT_CMD     8'h17
`define DYNAMIC_LOCK_WRITE_CMD    8'hfb
`define DYNAMIC_LOCK_WRITE_ALT_CMD 8'he1
`define PERSISTENT_LOCK_WRITE_CMD 8'hfd
`define PERSISTENT_LOCK_WRITE_4B_CMD 8'he3
`define PERSISTENT_LOCK_ERASE_CMD 8'he4
`define PROTECT_SCHEME_WRITE_CMD  8'h2f
`define PERSISTENT_LOCK_BIT_CMD   8'ha6
`define FREEZE_SET_CMD            8'h91
`define GANG_LOCK_CMD             8'h7e
`define GANG_UNLOCK_CMD           8'h98
`define PASSWORD_WRITE_CMD        8'he8
// ==========================================================
// timing counts in core_clk cycles
`define OP_CYCLES       16'd200
`define HALF_SCK_CYCLES 4'd8
// ==========================================================
// controller register offsets (byte addresses) and command word bit positions
`define CMD_OFFSET      4'h0
`define STAT_OFFSET     4'h4
`define WP_OFFSET       4'h8
`define CMD_SEND_DATA   16
`define CMD_RD_LSB      17
`endif

// >>> src/flash_types_pkg.sv
// types shared by both ends of the flash status link
// assumes: nothing beyond the constants header
package flash_types_pkg;
    // ==========================================================
    // device power-up sequencing
    typedef enum logic [0:0] {POWER_LOAD, RUNNING} dev_state_type;
    // host serial sequencer
    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL}
        host_state_type;
endpackage

// >>> src/spi_link_if.sv
// serial link between the flash status device and its host
// assumes: the host makes sck; so is always driven by the device
`timescale 1ns/10ps
interface spi_link_if;
    logic sck;   // serial clock from host
    logic ceN;   // chip select, active low
    logic si;    // host to device data
    logic so;    // device to host data
    logic wpN;   // write protect level, active low
    modport host  (output sck, output ceN, output si, output wpN, input so);
    modport flash (input sck, input ceN, input si, input wpN, output so);
endinterface // spi_link_if

// >>> src/sync_two_ff.sv
// two flip-flop synchroniser for pin levels
// assumes: inputs come from another clock domain
`timescale 1ns/10ps
module sync_two_ff #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;   // first stage, read only by dout
    // ==========================================================
    // two stages
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta_r <= RESET_VAL;
            dout   <= RESET_VAL;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule // sync_two_ff

// >>> verification/flash_status_properties.sv
// link timing checks between the flash host and device ends
// assumes: plain link signals from the interface, one core clock
`timescale 1ns/10ps
module flash_status_properties (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic ceN,
    input wire logic si,
    input wire logic so
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // sck halves
    sequence s_high8; sck [*8] ##1 !sck; endsequence
    sequence s_low8; (!sck) [*8]; endsequence
    property p_sck_high; $rose(sck) |-> s_high8; endproperty
    a_sck_high: assert property (p_sck_high)
        else $error("sck high half wrong");
    property p_sck_low; $fell(sck) |-> s_low8; endproperty
    a_sck_low: assert property (p_sck_low)
        else $error("sck low half wrong");
    property p_lead; $fell(ceN) |-> (!sck) [*7]; endproperty
    a_lead: assert property (p_lead) else $error("sck too soon");
    property p_ce_sck; ceN |-> !sck; endproperty
    a_ce_sck: assert property (p_ce_sck) else $error("sck outside frame");
    property p_si_stable; sck |-> $stable(si); endproperty
    a_si_stable: assert property (p_si_stable) else $error("si moved");
    property p_so_stable; sck |-> $stable(so); endproperty
    a_so_stable: assert property (p_so_stable) else $error("so moved");
    property p_so_idle; ceN [*6] |-> !so; endproperty
    a_so_idle: assert property (p_so_idle) else $error("so not idle");
    property p_ce_hold; $rose(ceN) |-> ceN [*8]; endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("frame gap short");
endmodule // flash_status_properties

// >>> verification/testbench.sv
// self-checking bench: wishbone host end driving the device end
// assumes: both ends meet in spi_link_if; checker sits beside it
`timescale 1ns/10ps
`include "flash_status_params.svh"
module testbench;
    logic core_clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
    logic [3:0] adr = 0, sel = 4'hf;
    logic [31:0] dat = 0, datO, rd;
    logic ack, opBusy, opSusp;
    logic [7:0] sv, ex, v, op;
    logic [311:0] wc = {152'h021232383e34d72021525cd8dcc76001426563,
                        160'h858364621518c5fbe1fde3e42fa6917e98e8c017};
    int fails = 0, compares = 0, seed = 15576, i;
    spi_link_if lnk();
    flash_status_host u_flash_status_host (.core_clk(core_clk),
        .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(datO), .ack_o(ack),
        .link(lnk.host));
    flash_status_dev u_flash_status_dev (.core_clk(core_clk), .rstn(rstn),
        .link(lnk.flash), .statusView(sv), .opBusy(opBusy),
        .opSuspended(opSusp));
    flash_status_properties u_props (.core_clk(core_clk), .rstn(rstn),
        .sck(lnk.sck), .ceN(lnk.ceN), .si(lnk.si), .so(lnk.so));
    initial forever #2 core_clk = ~core_clk;
    // ==========================================================
    // tasks
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
        do @(posedge core_clk); while (ack !== 1'b1);
        rd = datO;
        cyc <= 0; stb <= 0;
    endtask
    // one link frame, then wait until the host is idle again
    task fr(input logic [7:0] o, d, input logic s, input logic [2:0] n);
        wb(1, 4'h0, {12'h000, n, s, d, o});
        do wb(0, 4'h4, 0); while (rd[0] !== 1'b0);
        repeat (6) @(posedge core_clk);
    endtask
    task rs;
        fr(8'h05, 8'h00, 0, 3'd2);
        chk(rd[15:8], ex);
        chk(sv, ex);
    endtask
    task sw(input logic [7:0] d, input logic ok);
        fr(8'h06, 8'h00, 0, 0);
        fr(8'h01, d, 1, 0);
        chk(opBusy, ok);
        repeat (`OP_CYCLES + 16) @(posedge core_clk);
        ex = ok ? {d[7:2], 2'b00} : {ex[7:2], 2'b10};
        rs();
    endtask
    task test_done;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #300000;
        fails++;
        test_done();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1;
        repeat (4) @(posedge core_clk);
        ex = 8'h00;
        rs();
        wb(0, 4'hc, 0);
        chk(rd, 0);
        wb(0, 4'h8, 0);
        chk(rd[0], 1);
        for (i = 0; i < 39; i++) begin
            op = wc[311 - 8 * i -: 8];
            fr(op, $random(seed), op == 8'h01, 0);
            chk(sv, ex);
            chk(opBusy, 0);
        end
        $display("test inhibit done");
        fr(8'h06, 8'h00, 0, 0);
        ex = 8'h02;
        rs();
        fr(8'h04, 8'h00, 0, 0);
        ex = 8'h00;
        rs();
        repeat (4) begin
            v = $random(seed);
            sw(v & 8'h7f, 1);
        end
        $display("test status write done");
        sw(8'h80, 1);
        wb(1, 4'h8, 0);
        sw(8'h3c, 0);
        fr(8'h04, 8'h00, 0, 0);
        wb(1, 4'h8, 1);
        sw(8'h00, 1);
        $display("test lock done");
        fr(8'h06, 8'h00, 0, 0);
        fr(8'h02, 8'h00, 0, 0);
        fr(8'h04, 8'h00, 0, 0);
        chk({opBusy, sv[1]}, 2'b11);
        repeat (`OP_CYCLES + 16) @(posedge core_clk);
        chk({opBusy, sv}, 9'h000);
        fr(8'h06, 8'h00, 0, 0);
        fr(8'h02, 8'h00, 0, 0);
        fr(8'h75, 8'h00, 0, 0);
        chk({opBusy, opSusp}, 2'b01);
        fr(8'h7a, 8'h00, 0, 0);
        chk(opBusy, 1);
        repeat (`OP_CYCLES + 16) @(posedge core_clk);
        chk({opBusy, sv}, 9'h000);
        $display("test busy done");
        test_done();
    end
endmodule // testbench
